// File: design/dclar_params.svh
`ifndef DCLAR_PARAMS_SVH
`define DCLAR_PARAMS_SVH

// ********************************************************************
// Register pointers of the serial target port
// ********************************************************************
`define DCLAR_REG_CTRL   4'h0
`define DCLAR_REG_ITIME  4'h1
`define DCLAR_REG_TLO_L  4'h2
`define DCLAR_REG_TLO_H  4'h3
`define DCLAR_REG_THI_L  4'h4
`define DCLAR_REG_THI_H  4'h5
`define DCLAR_REG_PERS   4'h6
`define DCLAR_REG_STAT   4'h7
`define DCLAR_REG_CH0_L  4'h8
`define DCLAR_REG_CH0_H  4'h9
`define DCLAR_REG_CH1_L  4'ha
`define DCLAR_REG_CH1_H  4'hb

// ********************************************************************
// Field positions
// ********************************************************************
`define DCLAR_CTRL_EN    0
`define DCLAR_CTRL_IEN   1
`define DCLAR_STAT_VALID 0
`define DCLAR_STAT_INT   1
`define DCLAR_CMD_BIT    7

// ********************************************************************
// Reset values
// ********************************************************************
`define DCLAR_ITIME_RST  8'h0f
`define DCLAR_TLO_RST    16'h0000
`define DCLAR_THI_RST    16'hffff
`define DCLAR_PERS_RST   4'h0

// ********************************************************************
// Timing
// ********************************************************************
`define DCLAR_CLK_KHZ    100000
`define DCLAR_OSC_KHZ    750
`define DCLAR_OSC_DIV    (`DCLAR_CLK_KHZ / `DCLAR_OSC_KHZ)
`define DCLAR_ITIME_UNIT 16

`endif

// File: design/dclar_pkg.sv
`default_nettype none

package dclar_pkg;

	// Target port states.
	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_ACK,
		S_WR,
		S_RD,
		S_MACK
	} dclar_st_t;

	// Host-programmed configuration.
	typedef struct packed {
		logic [15:0] thr_hi;
		logic [15:0] thr_lo;
		logic [7:0]  itime;
		logic [3:0]  persist;
		logic        int_en;
		logic        en;
	} dclar_cfg_t;

endpackage

`default_nettype wire

// File: design/dclar_readout.sv
`timescale 1ns/1ps
`default_nettype none
`include "dclar_params.svh"

module dclar_readout
	import dclar_pkg::*;
#(
	parameter logic [6:0] ADDR_LOW   = 7'h10, // Arbitrary value.
	parameter logic [6:0] ADDR_HIGH  = 7'h11, // Arbitrary value.
	parameter logic [6:0] ADDR_FLOAT = 7'h12  // Arbitrary value.
)(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic [1:0] addr_sel_i,
	input  wire logic [1:0] ch_pulse_i,
	output logic            sda_o,
	output logic            sda_oe,
	output logic            int_o,
	output logic            int_oe
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	dclar_st_t   st_q;
	dclar_cfg_t  cfg_q;
	logic        scl_q, sda_q;
	logic [3:0]  bit_q, ptr_q, wr_ptr_q;
	logic [7:0]  sh_q, wr_dat_q, rd_byte;
	logic        rw_q, first_q, nack_q, wr_stb_q, clr_q;
	logic [6:0]  my_addr_q;
	logic        addr_done_q;
	logic [7:0]  div_q;
	logic        osc_tick_q;
	logic [15:0] integ_q, integ_len;
	logic        conv_end, conv_done_q, valid_q;
	logic [15:0] acc_q [2];
	logic [15:0] result_q [2];
	logic [7:0]  snap_q [2];
	logic [3:0]  oor_q;
	logic        out_of_range, fire, rd_load;
	logic        scl_rise, scl_fall, start, stop;

	// ****************************************************************
	// Bus edge detection
	// ****************************************************************

	// Inputs are already synchronous; one stage of history finds edges.
	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign start    = scl_i & scl_q & sda_q & ~sda_i;
	assign stop     = scl_i & scl_q & ~sda_q & sda_i;
	assign rd_load  = scl_fall & ((st_q == S_ACK & rw_q)
		| (st_q == S_MACK & ~nack_q));

	// History of the bus lines; the data driver never leaves zero.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_o <= 1'b0;
			int_o <= 1'b0;
		end
		else
		begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			sda_o <= 1'b0;
			int_o <= 1'b0;
		end
	end

	// ****************************************************************
	// Address strap
	// ****************************************************************

	// The pin is caught once after reset; moving it later has no effect.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			addr_done_q <= 1'b0;
			my_addr_q   <= ADDR_LOW;
		end
		else if (!addr_done_q)
		begin
			addr_done_q <= 1'b1;
			if (addr_sel_i[1])
				my_addr_q <= ADDR_FLOAT;
			else if (addr_sel_i[0])
				my_addr_q <= ADDR_HIGH;
			else
				my_addr_q <= ADDR_LOW;
		end
	end

	// ****************************************************************
	// Serial target
	// ****************************************************************

	// Byte returned to the host for the current pointer.
	always_comb
	begin
		rd_byte = 8'h00;
		case (ptr_q)
			`DCLAR_REG_CTRL:
			begin
				rd_byte[`DCLAR_CTRL_EN]  = cfg_q.en;
				rd_byte[`DCLAR_CTRL_IEN] = cfg_q.int_en;
			end
			`DCLAR_REG_ITIME: rd_byte = cfg_q.itime;
			`DCLAR_REG_TLO_L: rd_byte = cfg_q.thr_lo[7:0];
			`DCLAR_REG_TLO_H: rd_byte = cfg_q.thr_lo[15:8];
			`DCLAR_REG_THI_L: rd_byte = cfg_q.thr_hi[7:0];
			`DCLAR_REG_THI_H: rd_byte = cfg_q.thr_hi[15:8];
			`DCLAR_REG_PERS:  rd_byte = {4'h0, cfg_q.persist};
			`DCLAR_REG_STAT:
			begin
				rd_byte[`DCLAR_STAT_VALID] = valid_q;
				rd_byte[`DCLAR_STAT_INT]   = int_oe;
			end
			`DCLAR_REG_CH0_L: rd_byte = result_q[0][7:0];
			`DCLAR_REG_CH0_H: rd_byte = snap_q[0];
			`DCLAR_REG_CH1_L: rd_byte = result_q[1][7:0];
			`DCLAR_REG_CH1_H: rd_byte = snap_q[1];
			default:          rd_byte = 8'h00;
		endcase
	end

	// Data moves on the falling clock edge and is sampled on the rising
	// one, so the 100 MHz core sees every fast-mode bit many times.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q     <= S_IDLE;
			bit_q    <= 4'h0;
			sh_q     <= 8'h00;
			rw_q     <= 1'b0;
			first_q  <= 1'b0;
			nack_q   <= 1'b0;
			ptr_q    <= 4'h0;
			sda_oe   <= 1'b0;
			wr_stb_q <= 1'b0;
			clr_q    <= 1'b0;
			wr_ptr_q <= 4'h0;
			wr_dat_q <= 8'h00;
		end
		else
		begin
			wr_stb_q <= 1'b0;
			clr_q    <= 1'b0;
			if (start)
			begin
				st_q    <= S_ADDR;
				bit_q   <= 4'h0;
				first_q <= 1'b1;
				sda_oe  <= 1'b0;
			end
			else if (stop)
			begin
				st_q   <= S_IDLE;
				sda_oe <= 1'b0;
			end
			else if (scl_rise)
			begin
				case (st_q)
					S_ADDR, S_WR:
					begin
						sh_q  <= {sh_q[6:0], sda_i};
						bit_q <= bit_q + 4'h1;
					end
					S_RD:    bit_q  <= bit_q + 4'h1;
					S_MACK:  nack_q <= sda_i;
					default: ;
				endcase
			end
			else if (scl_fall)
			begin
				case (st_q)
					S_ADDR:
						if (bit_q == 4'h8)
						begin
							if (sh_q[7:1] == my_addr_q)
							begin
								st_q   <= S_ACK;
								rw_q   <= sh_q[0];
								sda_oe <= 1'b1;
							end
							else
								st_q <= S_IDLE;
						end
					S_WR:
						if (bit_q == 4'h8)
						begin
							st_q    <= S_ACK;
							sda_oe  <= 1'b1;
							first_q <= 1'b0;
							if (!first_q)
							begin
								wr_stb_q <= 1'b1;
								wr_ptr_q <= ptr_q;
								wr_dat_q <= sh_q;
								ptr_q    <= ptr_q + 4'h1;
							end
							else if (sh_q[`DCLAR_CMD_BIT])
								clr_q <= 1'b1;
							else
								ptr_q <= sh_q[3:0];
						end
					S_RD:
						if (bit_q == 4'h8)
						begin
							st_q   <= S_MACK;
							sda_oe <= 1'b0;
						end
						else
							sda_oe <= ~sh_q[~bit_q[2:0]];
					S_ACK, S_MACK:
						if (rd_load)
						begin
							st_q   <= S_RD;
							sh_q   <= rd_byte;
							sda_oe <= ~rd_byte[7];
							bit_q  <= 4'h0;
							ptr_q  <= ptr_q + 4'h1;
						end
						else if (st_q == S_ACK)
						begin
							st_q   <= S_WR;
							sda_oe <= 1'b0;
							bit_q  <= 4'h0;
						end
						else
							st_q <= S_IDLE;
					default: st_q <= S_IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// Configuration
	// ****************************************************************

	// Thresholds are written one byte at a time, so a host that wants a
	// glitch-free change should write while the interrupt is disabled.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cfg_q.en      <= 1'b0;
			cfg_q.int_en  <= 1'b0;
			cfg_q.itime   <= `DCLAR_ITIME_RST;
			cfg_q.thr_lo  <= `DCLAR_TLO_RST;
			cfg_q.thr_hi  <= `DCLAR_THI_RST;
			cfg_q.persist <= `DCLAR_PERS_RST;
		end
		else if (wr_stb_q)
		begin
			case (wr_ptr_q)
				`DCLAR_REG_CTRL:
				begin
					cfg_q.en     <= wr_dat_q[`DCLAR_CTRL_EN];
					cfg_q.int_en <= wr_dat_q[`DCLAR_CTRL_IEN];
				end
				`DCLAR_REG_ITIME: cfg_q.itime <= wr_dat_q;
				`DCLAR_REG_TLO_L: cfg_q.thr_lo[7:0]  <= wr_dat_q;
				`DCLAR_REG_TLO_H: cfg_q.thr_lo[15:8] <= wr_dat_q;
				`DCLAR_REG_THI_L: cfg_q.thr_hi[7:0]  <= wr_dat_q;
				`DCLAR_REG_THI_H: cfg_q.thr_hi[15:8] <= wr_dat_q;
				`DCLAR_REG_PERS:  cfg_q.persist <= wr_dat_q[3:0];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Oscillator and integration timer
	// ****************************************************************

	// The internal oscillator is a divided enable of the core clock.
	always_ff @(posedge clk)
	begin
		if (rst || div_q == 8'(`DCLAR_OSC_DIV - 1))
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
		osc_tick_q <= ~rst & (div_q == 8'(`DCLAR_OSC_DIV - 1));
	end

	assign integ_len = 16'(({8'h00, cfg_q.itime} + 16'h0001)
		* `DCLAR_ITIME_UNIT);
	assign conv_end  = cfg_q.en & osc_tick_q
		& (integ_q == integ_len - 16'h0001);

	// One timer serves both channels, so their periods cannot drift.
	always_ff @(posedge clk)
	begin
		if (rst || !cfg_q.en || conv_end)
			integ_q <= 16'h0000;
		else if (osc_tick_q)
			integ_q <= integ_q + 16'h0001;
		conv_done_q <= ~rst & conv_end;
		if (rst || !cfg_q.en)
			valid_q <= 1'b0;
		else if (conv_end)
			valid_q <= 1'b1;
	end

	// ****************************************************************
	// Per-channel accumulation and result buffering
	// ****************************************************************
	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		// A count arriving on the closing cycle opens the next period.
		always_ff @(posedge clk)
		begin
			if (rst || !cfg_q.en)
				acc_q[c] <= 16'h0000;
			else if (conv_end)
				acc_q[c] <= {15'h0000, ch_pulse_i[c]};
			else if (ch_pulse_i[c] && acc_q[c] != 16'hffff)
				acc_q[c] <= acc_q[c] + 16'h0001;
		end

		// Results change only on the closing cycle of a period.
		always_ff @(posedge clk)
		begin
			if (rst)
				result_q[c] <= 16'h0000;
			else if (conv_end)
				result_q[c] <= acc_q[c];
		end

		// Reading the low byte freezes the high byte for the next read.
		always_ff @(posedge clk)
		begin
			if (rst)
				snap_q[c] <= 8'h00;
			else if (rd_load && ptr_q == 4'(`DCLAR_REG_CH0_L + 2 * c))
				snap_q[c] <= result_q[c][15:8];
		end
	end

	// ****************************************************************
	// Threshold, persistence and interrupt
	// ****************************************************************
	assign out_of_range = result_q[0] > cfg_q.thr_hi
		|| result_q[0] < cfg_q.thr_lo;
	assign fire = conv_done_q & out_of_range
		& (({1'b0, oor_q} + 5'h01) >= {1'b0, cfg_q.persist});

	// Counts back-to-back out-of-range conversions; saturates at 15.
	always_ff @(posedge clk)
	begin
		if (rst || !cfg_q.en)
			oor_q <= 4'h0;
		else if (conv_done_q)
		begin
			if (!out_of_range)
				oor_q <= 4'h0;
			else if (oor_q != 4'hf)
				oor_q <= oor_q + 4'h1;
		end
	end

	// The pull-down itself is the flag; a new event beats a clear.
	always_ff @(posedge clk)
	begin
		if (rst)
			int_oe <= 1'b0;
		else if (fire && cfg_q.int_en)
			int_oe <= 1'b1;
		else if (clr_q)
			int_oe <= 1'b0;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_both_latch: assert property (@(posedge clk) disable iff (rst)
		conv_end |=> integ_q == 16'h0000 && conv_done_q)
		else $error("Channels did not close their period together.");
	a_result_copy: assert property (@(posedge clk) disable iff (rst)
		conv_end |=> result_q[0] == $past(acc_q[0])
			&& result_q[1] == $past(acc_q[1]))
		else $error("Result did not take its channel count.");
	a_result_hold: assert property (@(posedge clk) disable iff (rst)
		!conv_end |=> $stable(result_q[0]) && $stable(result_q[1]))
		else $error("Result changed outside a period end.");
	a_auto_restart: assert property (@(posedge clk) disable iff (rst)
		conv_end && cfg_q.en ##1 cfg_q.en [*2] |-> integ_q <= 16'h0001)
		else $error("Next integration did not start at once.");
	a_idle_release: assert property (@(posedge clk) disable iff (rst)
		st_q == S_IDLE |=> !sda_oe)
		else $error("Data line driven while the target is idle.");
	a_thr_write: assert property (@(posedge clk) disable iff (rst)
		wr_stb_q && wr_ptr_q == `DCLAR_REG_THI_H
		|=> cfg_q.thr_hi[15:8] == $past(wr_dat_q))
		else $error("Upper threshold write was lost.");
	a_int_cause: assert property (@(posedge clk) disable iff (rst)
		$rose(int_oe) |-> $past(conv_done_q) && $past(out_of_range))
		else $error("Interrupt rose without an out-of-range result.");
	a_persist_gate: assert property (@(posedge clk) disable iff (rst)
		conv_done_q && cfg_q.en && !out_of_range |=> oor_q == 4'h0)
		else $error("Persistence count survived an in-range result.");
	a_int_level: assert property (@(posedge clk) disable iff (rst)
		int_oe && !clr_q |=> int_oe)
		else $error("Interrupt dropped without a host clear.");
	a_osc_time: assert property (@(posedge clk) disable iff (rst)
		!osc_tick_q && cfg_q.en && $past(cfg_q.en) |=> $stable(integ_q))
		else $error("Integration timer moved without an oscillator tick.");
	a_addr_miss: assert property (@(posedge clk) disable iff (rst)
		st_q == S_ADDR && scl_fall && !start && !stop && bit_q == 4'h8
		&& sh_q[7:1] != my_addr_q |=> st_q == S_IDLE && !sda_oe)
		else $error("Target answered a foreign address.");

endmodule // dclar_readout

`default_nettype wire

// File: dv/dclar_host.sv
`timescale 1ns/1ps
`default_nettype none

module dclar_host
#(
	parameter int HALF = 125
)(
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      pull_low
);
	// ****************************************************************
	// Bus controller model
	// ****************************************************************
	localparam int Q = HALF / 2;

	// The bus starts idle with both lines released to their pull-ups.
	initial
	begin
		scl = 1'b1;
		pull_low = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Data moves only mid-low phase, so no false start or stop is seen.
	task automatic bit_x(input logic b, output logic s);
		hold(Q);
		pull_low = ~b;
		hold(HALF - Q);
		scl = 1'b1;
		hold(HALF);
		s = sda;
		scl = 1'b0;
	endtask

	task automatic start();
		pull_low = 1'b0;
		hold(HALF);
		pull_low = 1'b1;
		hold(HALF);
		scl = 1'b0;
	endtask

	task automatic stop();
		hold(Q);
		pull_low = 1'b1;
		hold(HALF - Q);
		scl = 1'b1;
		hold(HALF);
		pull_low = 1'b0;
		hold(HALF);
	endtask

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(b[i], s);
		bit_x(1'b1, s);
		ack = ~s;
	endtask

	task automatic get_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(1'b1, s);
			b[i] = s;
		end
		bit_x(nack, s);
	endtask
endmodule // dclar_host

`default_nettype wire

// File: dv/dual_channel_light_adc_readout_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dclar_params.svh"

module dual_channel_light_adc_readout_tb_top;
	// ****************************************************************
	// Bench
	// ****************************************************************
	localparam logic [6:0] A_LO = 7'h10; // Arbitrary value.
	localparam logic [6:0] A_HI = 7'h11; // Arbitrary value.
	localparam logic [6:0] A_FL = 7'h12; // Arbitrary value.
	localparam int         P    = `DCLAR_ITIME_UNIT * `DCLAR_OSC_DIV;

	logic       clk      = 1'b0;
	logic       rst      = 1'b1;
	logic [1:0] addr_sel = 2'b00;
	logic [1:0] ch_pulse = 2'b00;
	logic       pulse_on = 1'b0;
	logic [6:0] dev_addr = A_LO;
	logic       scl;
	logic       host_low;
	logic       sda_o;
	logic       sda_oe;
	logic       int_o;
	logic       int_oe;
	wire logic  sda;
	int         num_errors = 0;
	int         n_checks   = 0;

	// The data line has a pull-up; either party may pull it low.
	assign sda = ~(sda_oe | host_low);

	always #5 clk = ~clk;

	// Channel 1 pulses every other cycle, so over any whole period it
	// counts exactly half of channel 0, whatever the period's phase.
	always @(negedge clk)
		ch_pulse <= pulse_on ? {~ch_pulse[1], 1'b1} : 2'b00;

	dclar_readout #(
		.ADDR_LOW   (A_LO),
		.ADDR_HIGH  (A_HI),
		.ADDR_FLOAT (A_FL)
	) dut (
		.clk        (clk),
		.rst        (rst),
		.scl_i      (scl),
		.sda_i      (sda),
		.addr_sel_i (addr_sel),
		.ch_pulse_i (ch_pulse),
		.sda_o      (sda_o),
		.sda_oe     (sda_oe),
		.int_o      (int_o),
		.int_oe     (int_oe)
	);

	dclar_host #(
		.HALF (125)
	) host (
		.clk      (clk),
		.sda      (sda),
		.scl      (scl),
		.pull_low (host_low)
	);

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic do_reset(input logic [1:0] sel);
		@(negedge clk);
		rst = 1'b1;
		addr_sel = sel;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	task automatic probe(input logic [6:0] a, output logic ack);
		host.start();
		host.put_byte({a, 1'b0}, ack);
		host.stop();
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [63:0] d,
		input int n);
		logic ack;
		host.start();
		host.put_byte({dev_addr, 1'b0}, ack);
		chk("write ack", 32'h1, {31'h0, ack});
		host.put_byte(ptr, ack);
		for (int i = 0; i < n; i++)
			host.put_byte(d[8*i +: 8], ack);
		host.stop();
	endtask

	// Bytes come back little end first into the low end of d.
	task automatic rd(input logic [7:0] ptr, input int n,
		output logic [31:0] d);
		logic       ack;
		logic [7:0] b;
		d = '0;
		wr(ptr, 64'h0, 0);
		host.start();
		host.put_byte({dev_addr, 1'b1}, ack);
		for (int i = 0; i < n; i++)
		begin
			host.get_byte(i == n - 1, b);
			d[8*i +: 8] = b;
		end
		host.stop();
	endtask

	task automatic wait_int(input int n);
		for (int i = 0; i < n && int_oe !== 1'b1; i++)
			@(negedge clk);
	endtask

	task automatic t_strap();
		logic [6:0] adr [3];
		logic [1:0] sel [3];
		logic       ack;
		adr = '{A_LO, A_HI, A_FL};
		sel = '{2'b00, 2'b01, 2'b10};
		for (int s = 0; s < 3; s++)
		begin
			do_reset(sel[s]);
			probe(adr[s], ack);
			chk("own address ack", 32'h1, {31'h0, ack});
		end
		probe(A_LO, ack);
		chk("foreign address ack", 32'h0, {31'h0, ack});
		dev_addr = A_FL;
		$display("test strap done");
	endtask

	task automatic t_reset();
		logic [31:0] d;
		do_reset(2'b10);
		chk("pins after reset", 32'h0,
			{28'h0, sda_o, sda_oe, int_o, int_oe});
		rd(8'h04, 2, d);
		chk("upper threshold reset", 32'hffff, d);
		$display("test reset done");
	endtask

	// Upper threshold below even the shortened first period's count, so
	// every conversion is out of range; persistence of three. The first
	// check falls between the second and the third period end.
	task automatic t_persist();
		logic [31:0] d;
		wr(8'h01, 64'h0000_0307_0000_0000, 6);
		pulse_on = 1'b1;
		wr(8'h00, 64'h03, 1);
		repeat (2 * P + 600) @(negedge clk);
		chk("int before third", 32'h0, {31'h0, int_oe});
		wait_int(1000);
		chk("int at third", 32'h1, {31'h0, int_oe});
		rd(8'h08, 4, d);
		chk("results", {16'(P / 2), 16'(P)}, d);
		chk("int held", 32'h1, {31'h0, int_oe});
		$display("test persist done");
	endtask

	task automatic t_clear();
		wr(8'h04, 64'hffff, 2);
		chk("int kept in range", 32'h1, {31'h0, int_oe});
		wr(8'h80, 64'h0, 0);
		chk("int after clear", 32'h0, {31'h0, int_oe});
		chk("int driver value", 32'h0, {31'h0, int_o});
		repeat (2 * P) @(negedge clk);
		chk("int stays clear", 32'h0, {31'h0, int_oe});
		$display("test clear done");
	endtask

	task automatic t_low();
		wr(8'h02, 64'h0900, 2);
		chk("int before low run", 32'h0, {31'h0, int_oe});
		wait_int(4 * P);
		chk("int below lower", 32'h1, {31'h0, int_oe});
		$display("test low done");
	endtask

	// A hang counts as a mismatch and ends the run the usual way; the
	// tests need some 110000 cycles, so this leaves a fair margin.
	initial
	begin
		repeat (150000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end

	initial
	begin
		t_strap();
		t_reset();
		t_persist();
		t_clear();
		t_low();
		tally_and_finish();
	end
endmodule // dual_channel_light_adc_readout_tb_top

`default_nettype wire
